// ---- verilog/bcs_regs.svh ----
// Constants for the bus cycle status encoder: field values and reset values.
// Assumes it is included by its bare name from the package and the design modules.
//
// Overview of operation
// - Status pair low only in start state
// - Status pins float high during hold acknowledge
// - Interrupt acknowledge drives all four lines low
// - Patterns 01 and 10 reserved with code and M/IO both low, never emitted there
// - Both status bits high means no cycle
// - Halt or shutdown chosen by address bit one
// - Memory read: high bit 0, low bit 1
// - Memory write: high bit 1, low bit 0
`ifndef BCS_REGS_SVH
`define BCS_REGS_SVH

// ****************************************
// Line levels per cycle kind
// ****************************************
`define BCS_COD_INTACK 1'h0
`define BCS_MIO_IO 1'h0
`define BCS_MIO_MEM 1'h1
`define BCS_STATUS_NONE 2'h3
`define BCS_STATUS_INTACK 2'h0
`define BCS_STATUS_HALT 2'h0
`define BCS_STATUS_READ 2'h1
`define BCS_STATUS_WRITE 2'h2
`define BCS_ADDR_HALT 1'h1
`define BCS_ADDR_SHUTDOWN 1'h0

// ****************************************
// Reset values
// ****************************************
`define BCS_RST_COD 1'h1
`define BCS_RST_MIO 1'h1
`define BCS_RST_ADDR 1'h0
`define BCS_RST_PIN 1'h1

`endif

// ---- verilog/bcs_pkg.sv ----
// Types shared by the bus cycle status encoder modules.
// Assumes bcs_regs.svh is on the include path.
package bcs_pkg;
    `include "bcs_regs.svh"

    typedef enum logic [2:0] {
        BCS_KIND_INTACK = 3'h0,
        BCS_KIND_HALT = 3'h1,
        BCS_KIND_SHUTDOWN = 3'h2,
        BCS_KIND_MEM_READ = 3'h3,
        BCS_KIND_MEM_WRITE = 3'h4
    } bcs_kind_e;

    typedef enum logic [1:0] {
        BCS_ST_IDLE = 2'h0,
        BCS_ST_START = 2'h1,
        BCS_ST_TAIL = 2'h2,
        BCS_ST_HOLD = 2'h3
    } bcs_state_e;
endpackage

// ---- verilog/bcs_pin_cell.sv ----
// One registered status pin with its output enable.
// Assumes i_value and i_drive come from logic on the same clock.
`include "bcs_regs.svh"

module bcs_pin_cell (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_value,
    input wire logic i_drive,
    output logic o_pin,
    output logic o_pin_oe
);
    import bcs_pkg::*;

    logic next_pin;
    logic next_pin_oe;

    // Released pin reads as one, so undriven value is kept high
    always_comb begin
        next_pin = i_drive ? i_value : `BCS_RST_PIN;
        next_pin_oe = i_drive;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            o_pin <= `BCS_RST_PIN;
            o_pin_oe <= 1'h1;
        end else begin
            o_pin <= next_pin;
            o_pin_oe <= next_pin_oe;
        end
    end
endmodule // bcs_pin_cell

// ---- verilog/bcs_encoder.sv ----
// Bus cycle status encoder: turns cycle requests from the core into status lines.
// Assumes requests and hold requests come from logic on i_clock; pins float to one.
`include "bcs_regs.svh"

module bcs_encoder (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_cycle_req,
    input wire bcs_pkg::bcs_kind_e i_cycle_kind,
    input wire logic i_hold_req,
    output logic o_req_ready,
    output logic o_cycle_status_hi_n,
    output logic o_cycle_status_hi_n_oe,
    output logic o_cycle_status_lo_n,
    output logic o_cycle_status_lo_n_oe,
    output logic o_cod_intack,
    output logic o_mem_io,
    output logic o_addr_bit_one,
    output logic o_bus_start_state,
    output logic o_hold_ack
);
    import bcs_pkg::*;

    bcs_state_e state;
    bcs_state_e next_state;
    logic cod;
    logic next_cod;
    logic mio;
    logic next_mio;
    logic a1;
    logic next_a1;
    logic start;
    logic next_start;
    logic hold_ack;
    logic next_hold_ack;
    logic ready;
    logic next_ready;
    logic [1:0] next_status;
    logic next_drive;
    logic kind_ok;
    logic [1:0] kind_status;
    logic kind_cod;
    logic kind_mio;
    logic kind_a1;
    logic take;

    // ****************************************
    // Cycle kind decode
    // ****************************************
    // Unknown kinds are refused so no reserved pattern can leave
    always_comb begin
        kind_ok = 1'h1;
        kind_cod = `BCS_COD_INTACK;
        kind_mio = `BCS_MIO_MEM;
        kind_a1 = a1;
        kind_status = `BCS_STATUS_NONE;
        case (i_cycle_kind)
            BCS_KIND_INTACK: begin
                kind_mio = `BCS_MIO_IO;
                kind_status = `BCS_STATUS_INTACK;
                kind_a1 = `BCS_ADDR_SHUTDOWN;
            end
            BCS_KIND_HALT: begin
                kind_status = `BCS_STATUS_HALT;
                kind_a1 = `BCS_ADDR_HALT;
            end
            BCS_KIND_SHUTDOWN: begin
                kind_status = `BCS_STATUS_HALT;
                kind_a1 = `BCS_ADDR_SHUTDOWN;
            end
            BCS_KIND_MEM_READ: begin
                kind_status = `BCS_STATUS_READ;
            end
            BCS_KIND_MEM_WRITE: begin
                kind_status = `BCS_STATUS_WRITE;
            end
            default: begin
                kind_ok = 1'h0;
            end
        endcase
    end

    // Hold request beats a cycle request in the same cycle
    assign take = i_cycle_req && ready && !i_hold_req && kind_ok;

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        next_state = state;
        next_cod = cod;
        next_mio = mio;
        next_a1 = a1;
        next_start = 1'h0;
        next_status = `BCS_STATUS_NONE;
        case (state)
            BCS_ST_IDLE: begin
                if (i_hold_req) begin
                    next_state = BCS_ST_HOLD;
                end else if (take) begin
                    next_state = BCS_ST_START;
                    next_cod = kind_cod;
                    next_mio = kind_mio;
                    next_a1 = kind_a1;
                    next_start = 1'h1;
                    next_status = kind_status;
                end
            end
            BCS_ST_START: begin
                next_state = BCS_ST_TAIL;
            end
            BCS_ST_TAIL: begin
                next_state = BCS_ST_IDLE;
            end
            BCS_ST_HOLD: begin
                if (!i_hold_req) begin
                    next_state = BCS_ST_IDLE;
                end
            end
            default: begin
                next_state = BCS_ST_IDLE;
            end
        endcase
        next_hold_ack = (next_state == BCS_ST_HOLD);
        next_drive = !next_hold_ack;
        next_ready = (next_state == BCS_ST_IDLE);
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            state <= BCS_ST_IDLE;
            cod <= `BCS_RST_COD;
            mio <= `BCS_RST_MIO;
            a1 <= `BCS_RST_ADDR;
            start <= 1'h0;
            hold_ack <= 1'h0;
            ready <= 1'h0;
        end else begin
            state <= next_state;
            cod <= next_cod;
            mio <= next_mio;
            a1 <= next_a1;
            start <= next_start;
            hold_ack <= next_hold_ack;
            ready <= next_ready;
        end
    end

    // ****************************************
    // Status pins
    // ****************************************
    bcs_pin_cell u_pin_hi (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_value(next_status[1]),
        .i_drive(next_drive),
        .o_pin(o_cycle_status_hi_n),
        .o_pin_oe(o_cycle_status_hi_n_oe)
    );

    bcs_pin_cell u_pin_lo (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_value(next_status[0]),
        .i_drive(next_drive),
        .o_pin(o_cycle_status_lo_n),
        .o_pin_oe(o_cycle_status_lo_n_oe)
    );

    assign o_req_ready = ready;
    assign o_cod_intack = cod;
    assign o_mem_io = mio;
    assign o_addr_bit_one = a1;
    assign o_bus_start_state = start;
    assign o_hold_ack = hold_ack;

    // ****************************************
    // Checks
    // ****************************************
    AST_START_ONE_CYCLE: assert property (@(posedge i_clock) disable iff (!i_rstn)
        take |=> o_bus_start_state ##1 (!o_bus_start_state && o_cycle_status_hi_n && o_cycle_status_lo_n))
        else $error("Start state not exactly one cycle");

    AST_LOW_ONLY_IN_START: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (!o_cycle_status_hi_n || !o_cycle_status_lo_n) == o_bus_start_state)
        else $error("Status low outside start state");

    AST_HOLD_FLOATS: assert property (@(posedge i_clock) disable iff (!i_rstn)
        o_hold_ack |-> (!o_cycle_status_hi_n_oe && !o_cycle_status_lo_n_oe
            && o_cycle_status_hi_n && o_cycle_status_lo_n))
        else $error("Status driven during hold acknowledge");

    AST_HOLD_GRANT: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (state == BCS_ST_IDLE && i_hold_req) |=> (o_hold_ack && !o_bus_start_state))
        else $error("Hold not granted from idle");

    AST_INTACK_CODE: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (take && i_cycle_kind == BCS_KIND_INTACK) |=> (!o_cod_intack && !o_mem_io
            && !o_cycle_status_hi_n && !o_cycle_status_lo_n))
        else $error("Interrupt acknowledge code wrong");

    AST_NO_RESERVED: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (!o_cod_intack && !o_mem_io) |-> (o_cycle_status_hi_n == o_cycle_status_lo_n))
        else $error("Reserved status pattern emitted");

    AST_NONE_NO_START: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (o_cycle_status_hi_n && o_cycle_status_lo_n) |-> !o_bus_start_state)
        else $error("Start state with idle status");

    AST_HALT_SHUTDOWN: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (take && (i_cycle_kind == BCS_KIND_HALT || i_cycle_kind == BCS_KIND_SHUTDOWN))
        |=> (o_mem_io && !o_cod_intack && !o_cycle_status_hi_n && !o_cycle_status_lo_n
            && o_addr_bit_one == ($past(i_cycle_kind) == BCS_KIND_HALT)))
        else $error("Halt or shutdown code wrong");

    AST_MEM_READ: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (take && i_cycle_kind == BCS_KIND_MEM_READ) |=> (o_mem_io && !o_cod_intack
            && !o_cycle_status_hi_n && o_cycle_status_lo_n))
        else $error("Memory read code wrong");

    AST_MEM_WRITE: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (take && i_cycle_kind == BCS_KIND_MEM_WRITE) |=> (o_mem_io && !o_cod_intack
            && o_cycle_status_hi_n && !o_cycle_status_lo_n))
        else $error("Memory write code wrong");
endmodule // bcs_encoder

// ---- verif/bcs_decoder_model.sv ----
// Model of the bus controller that decodes the cycle status lines.
// Assumes pull-ups on both status pins and one shared clock.
module bcs_decoder_model (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_hi_n,
    input wire logic i_hi_oe,
    input wire logic i_lo_n,
    input wire logic i_lo_oe,
    input wire logic i_cod,
    input wire logic i_mio,
    input wire logic i_addr,
    output logic o_started,
    output int o_kind,
    output logic o_reserved
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] stat;
    // Released pins read high through the pull-ups
    assign stat = {i_hi_oe ? i_hi_n : 1'b1, i_lo_oe ? i_lo_n : 1'b1};
    always @(posedge i_clock) begin
        o_started <= 1'b0;
        o_reserved <= 1'b0;
        if (!i_rstn || stat === 2'h3) begin
            o_started <= 1'b0;
        end else if (!i_cod && !i_mio && stat !== 2'h0) begin
            o_reserved <= 1'b1;
        end else begin
            o_started <= 1'b1;
            if (i_cod) begin
                o_kind <= -1;
            end else if (stat === 2'h0) begin
                o_kind <= !i_mio ? 0 : (i_addr ? 1 : 2);
            end else begin
                o_kind <= (stat === 2'h1) ? 3 : 4;
            end
        end
    end
endmodule // bcs_decoder_model

// ---- verif/bcs_encoder_tb.sv ----
// Self-checking bench for the status encoder with a decoding controller.
// Assumes the package and header are compiled first.
module bcs_encoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bcs_pkg::*;
    logic i_clock = 1'b0;
    logic i_rstn = 1'b0;
    logic i_cycle_req = 1'b0;
    bcs_kind_e i_cycle_kind = BCS_KIND_INTACK;
    logic i_hold_req = 1'b0;
    logic ready, hi_n, hi_oe, lo_n, lo_oe, cod, mio, addr, start, hack, started, resv;
    int kind_seen;
    int exp_q[$];
    int bad_count = 0;
    int checks_done = 0;
    bit watch = 1'b0;
    always #12.5 i_clock = ~i_clock;
    bcs_encoder dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_cycle_req(i_cycle_req),
        .i_cycle_kind(i_cycle_kind), .i_hold_req(i_hold_req), .o_req_ready(ready),
        .o_cycle_status_hi_n(hi_n), .o_cycle_status_hi_n_oe(hi_oe), .o_cycle_status_lo_n(lo_n),
        .o_cycle_status_lo_n_oe(lo_oe), .o_cod_intack(cod), .o_mem_io(mio), .o_addr_bit_one(addr),
        .o_bus_start_state(start), .o_hold_ack(hack));
    bcs_decoder_model ctl (.i_clock(i_clock), .i_rstn(i_rstn), .i_hi_n(hi_n), .i_hi_oe(hi_oe),
        .i_lo_n(lo_n), .i_lo_oe(lo_oe), .i_cod(cod), .i_mio(mio), .i_addr(addr),
        .o_started(started), .o_kind(kind_seen), .o_reserved(resv));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input bit ok, input string msg);
        checks_done++;
        if (!ok) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    // Refused requests are predicted here and must leave no trace
    task automatic issue(input int k, input bit hold);
        int n;
        bit take;
        n = 0;
        while (ready !== 1'b1 && !hold && n < 20) begin
            @(posedge i_clock);
            #2;
            n++;
        end
        if (ready !== 1'b1 && !hold) begin
            check(1'b0, "ready never came");
            end_sim();
        end
        i_cycle_kind = bcs_kind_e'(k[2:0]);
        i_cycle_req = 1'b1;
        take = ready === 1'b1 && i_hold_req === 1'b0 && k < 5;
        @(posedge i_clock);
        #2;
        i_cycle_req = 1'b0;
        if (take) begin
            exp_q.push_back(k);
        end
        // One idle edge so the next call never re-raises the request in this step
        @(posedge i_clock);
        #2;
    endtask
    always @(negedge i_clock) begin
        if (watch) begin
            check((start === 1'b1) === ({hi_n, lo_n} !== 2'h3 && hi_oe && lo_oe), "start and status");
            check(resv === 1'b0, "reserved pattern seen");
            check(hack !== 1'b1 || {hi_oe, lo_oe} === 2'h0, "pins driven in hold");
            if (started === 1'b1) begin
                check(exp_q.size() > 0 && kind_seen == exp_q.pop_front(), "wrong cycle kind");
            end
        end
    end
    initial begin
        void'($urandom(19881));
        repeat (6) @(posedge i_clock);
        #2;
        i_rstn = 1'b1;
        check(hack === 1'b0 && start === 1'b0 && {hi_n, lo_n, cod, mio, addr} === 5'h1E, "reset");
        watch = 1'b1;
        for (int k = 0; k < 8; k++) issue(k, 1'b0);
        $display("test kinds done");
        for (int i = 0; i < 60; i++) begin
            i_hold_req = ($urandom_range(0, 5) == 0);
            issue($urandom_range(0, 7), i_hold_req);
        end
        $display("test random done");
        i_hold_req = 1'b1;
        repeat (3) @(posedge i_clock);
        #2;
        check(hack === 1'b1 && ready === 1'b0, "hold not taken");
        issue(3, 1'b1);
        i_hold_req = 1'b0;
        repeat (2) @(posedge i_clock);
        #2;
        check(hack === 1'b0 && hi_oe === 1'b1 && lo_oe === 1'b1, "hold not left");
        issue(4, 1'b0);
        $display("test hold done");
        repeat (4) @(posedge i_clock);
        check(exp_q.size() == 0, "cycles missing");
        end_sim();
    end
endmodule // bcs_encoder_tb
